// ---- src/ppom_defines.svh ----
// Register map, field positions, reset values and sizes of the pin override mux.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef PPOM_DEFINES_SVH
`define PPOM_DEFINES_SVH

`define PPOM_NPIN 8
`define PPOM_AW 8

`define PPOM_OFS_DIR_A 8'h00
`define PPOM_OFS_OUT_A 8'h04
`define PPOM_OFS_IN_A 8'h08
`define PPOM_OFS_DIR_B 8'h0c
`define PPOM_OFS_OUT_B 8'h10
`define PPOM_OFS_IN_B 8'h14
`define PPOM_OFS_PORT_CTRL 8'h18
`define PPOM_OFS_MCU_CTRL 8'h1c

`define PPOM_BIT_PUD_A 0
`define PPOM_BIT_PUD_B 1
`define PPOM_BIT_BBM_A 4
`define PPOM_BIT_BBM_B 5
`define PPOM_BIT_GLOBAL_PUD 4

`define PPOM_RST_PORT_CTRL 8'h00
`define PPOM_RST_MCU_CTRL 8'h00
`define PPOM_RST_DIR 8'h00
`define PPOM_RST_OUT 8'h00

`endif

// ---- src/ppom_pkg.sv ----
// Types shared by the pin override mux files.
// Assumes ppom_defines.svh holds all numbers.
`include "ppom_defines.svh"

package ppom_pkg;
  typedef logic [7:0] ppom_byte_t;
  typedef logic [31:0] ppom_word_t;
  typedef logic [`PPOM_AW-1:0] ppom_addr_t;
endpackage

// ---- src/ppom_sync2.sv ----
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a level that may change at any time.
`timescale 1ns/100ps

module ppom_sync2 #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  initial begin
    if (W < 1) $error("ppom_sync2: W must be at least 1");
  end

  // First stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

// ---- src/ppom_pin.sv ----
// One pin of the override mux: pull-up, driver enable, driven value, input gate.
// Assumes register bits and override signals come from the clk domain.
`timescale 1ns/100ps

module ppom_pin (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dir_bit,
  input wire logic out_bit,
  input wire logic pud_eff,
  input wire logic bbm_hold,
  input wire logic sleep_clamp,
  input wire logic pu_oe,
  input wire logic pu_ov,
  input wire logic dd_oe,
  input wire logic dd_ov,
  input wire logic pv_oe,
  input wire logic pv_ov,
  input wire logic die_oe,
  input wire logic die_ov,
  output logic din_en,
  output logic pad_out_ff,
  output logic pad_oe_n_ff,
  output logic pullup_ff
);
  logic nxt_pullup;
  logic nxt_drv;
  logic nxt_out;

  always_comb begin
    nxt_pullup = pu_oe ? pu_ov : (!dir_bit && out_bit && !pud_eff);
    nxt_drv = (dd_oe ? dd_ov : dir_bit) && !bbm_hold;
    nxt_out = pv_oe ? pv_ov : out_bit;
    din_en = die_oe ? die_ov : !sleep_clamp;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_ff <= 1'b0;
      pad_oe_n_ff <= 1'b1;
      pad_out_ff <= 1'b0;
    end else begin
      pullup_ff <= nxt_pullup;
      pad_oe_n_ff <= !nxt_drv;
      // Value only matters while driving; low keeps the pad quiet otherwise
      pad_out_ff <= nxt_drv && nxt_out;
    end
  end
endmodule

// ---- src/ppom_top.sv ----
// Port pin override mux for two 8-pin ports with an APB register slave.
// Assumes pads outside resolve drive and pull-up; peripherals drive overrides on clk.
`timescale 1ns/100ps

module ppom_top import ppom_pkg::*; #(
  parameter int NPIN = `PPOM_NPIN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PPOM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_clamp,
  input wire logic [2*NPIN-1:0] pad_in,
  output logic [2*NPIN-1:0] pad_out,
  output logic [2*NPIN-1:0] pad_oe_n,
  output logic [2*NPIN-1:0] pullup_en,
  output logic [2*NPIN-1:0] alt_func_raw_input,
  input wire logic [2*NPIN-1:0] pullup_override_en,
  input wire logic [2*NPIN-1:0] pullup_override_val,
  input wire logic [2*NPIN-1:0] dir_override_en,
  input wire logic [2*NPIN-1:0] dir_override_val,
  input wire logic [2*NPIN-1:0] outval_override_en,
  input wire logic [2*NPIN-1:0] outval_override_val,
  input wire logic [2*NPIN-1:0] toggle_override_en,
  input wire logic [2*NPIN-1:0] input_gate_override_en,
  input wire logic [2*NPIN-1:0] input_gate_override_val
);
  localparam int NP = 2 * NPIN;

  logic [NP-1:0] dir_ff;
  logic [NP-1:0] out_ff;
  logic [NP-1:0] hold_ff;
  logic [NP-1:0] pin_sync;
  logic [NP-1:0] pud_eff;
  logic [NP-1:0] din_en;
  logic [NP-1:0] nxt_dir;
  logic [NP-1:0] nxt_out;
  logic [NP-1:0] nxt_hold;
  ppom_byte_t port_ctrl_ff;
  ppom_byte_t mcu_ctrl_ff;
  logic pready_ff;
  logic pslverr_ff;
  ppom_word_t prdata_ff;
  ppom_word_t nxt_prdata;
  logic nxt_err;
  logic wr_en;
  logic [1:0] wr_dir;
  logic [1:0] wr_out;
  logic [1:0] wr_in;
  logic [1:0] bbm;
  logic [1:0] port_pud;

  initial begin
    if (NPIN < 1 || NPIN > 8) $error("ppom_top: NPIN must be 1 to 8");
  end

  // APB: one access per setup/access pair, no wait states
  assign wr_en = psel && penable && pwrite && pready_ff;

  always_comb begin
    wr_dir = '0;
    wr_out = '0;
    wr_in = '0;
    if (wr_en) begin
      case (paddr)
        `PPOM_OFS_DIR_A: wr_dir[0] = 1'b1;
        `PPOM_OFS_OUT_A: wr_out[0] = 1'b1;
        `PPOM_OFS_IN_A: wr_in[0] = 1'b1;
        `PPOM_OFS_DIR_B: wr_dir[1] = 1'b1;
        `PPOM_OFS_OUT_B: wr_out[1] = 1'b1;
        `PPOM_OFS_IN_B: wr_in[1] = 1'b1;
        default: ;
      endcase
    end
  end

  always_comb begin
    nxt_prdata = '0;
    nxt_err = 1'b0;
    case (paddr)
      `PPOM_OFS_DIR_A: nxt_prdata[NPIN-1:0] = dir_ff[0 +: NPIN];
      `PPOM_OFS_OUT_A: nxt_prdata[NPIN-1:0] = out_ff[0 +: NPIN];
      `PPOM_OFS_IN_A: nxt_prdata[NPIN-1:0] = pin_sync[0 +: NPIN];
      `PPOM_OFS_DIR_B: nxt_prdata[NPIN-1:0] = dir_ff[NPIN +: NPIN];
      `PPOM_OFS_OUT_B: nxt_prdata[NPIN-1:0] = out_ff[NPIN +: NPIN];
      `PPOM_OFS_IN_B: nxt_prdata[NPIN-1:0] = pin_sync[NPIN +: NPIN];
      `PPOM_OFS_PORT_CTRL: nxt_prdata[7:0] = port_ctrl_ff;
      `PPOM_OFS_MCU_CTRL: nxt_prdata[7:0] = mcu_ctrl_ff;
      default: nxt_err = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && nxt_err;
      if (psel && !penable && !pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // Control registers; unassigned bits are plain storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_ctrl_ff <= `PPOM_RST_PORT_CTRL;
      mcu_ctrl_ff <= `PPOM_RST_MCU_CTRL;
    end else if (wr_en && paddr == `PPOM_OFS_PORT_CTRL) begin
      port_ctrl_ff <= pwdata[7:0];
    end else if (wr_en && paddr == `PPOM_OFS_MCU_CTRL) begin
      mcu_ctrl_ff <= pwdata[7:0];
    end
  end

  assign bbm[0] = port_ctrl_ff[`PPOM_BIT_BBM_A];
  assign bbm[1] = port_ctrl_ff[`PPOM_BIT_BBM_B];
  assign port_pud[0] = port_ctrl_ff[`PPOM_BIT_PUD_A];
  assign port_pud[1] = port_ctrl_ff[`PPOM_BIT_PUD_B];

  // Per-port write strobes, shared global pull-up disable
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      nxt_dir[p*NPIN +: NPIN] = wr_dir[p] ? pwdata[NPIN-1:0] : dir_ff[p*NPIN +: NPIN];
      // Toggle sources stack: write, then input-register toggle, then peripheral toggle
      nxt_out[p*NPIN +: NPIN] = (wr_out[p] ? pwdata[NPIN-1:0] : out_ff[p*NPIN +: NPIN])
        ^ (wr_in[p] ? pwdata[NPIN-1:0] : '0)
        ^ toggle_override_en[p*NPIN +: NPIN];
      // Only an input-to-output write arms the gap
      nxt_hold[p*NPIN +: NPIN] = (wr_dir[p] && bbm[p])
        ? (pwdata[NPIN-1:0] & ~dir_ff[p*NPIN +: NPIN]) : '0;
      pud_eff[p*NPIN +: NPIN] = {NPIN{port_pud[p] | mcu_ctrl_ff[`PPOM_BIT_GLOBAL_PUD]}};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_ff <= '0;
      out_ff <= '0;
    end else begin
      dir_ff <= nxt_dir;
      out_ff <= nxt_out;
    end
  end

  // Gap lasts one cycle; writes come at most every other cycle and only re-arm a pin that is still an input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= '0;
    end else begin
      hold_ff <= nxt_hold;
    end
  end

  ppom_sync2 #(.W(NP)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(alt_func_raw_input),
    .q(pin_sync)
  );

  // Raw gated input skips the synchroniser so peripherals may clock from it
  assign alt_func_raw_input = pad_in & din_en;

  for (genvar i = 0; i < NP; i++) begin : g_pin
    ppom_pin u_pin (
      .clk(clk),
      .rst_n(rst_n),
      .dir_bit(dir_ff[i]),
      .out_bit(out_ff[i]),
      .pud_eff(pud_eff[i]),
      .bbm_hold(hold_ff[i]),
      .sleep_clamp(sleep_clamp),
      .pu_oe(pullup_override_en[i]),
      .pu_ov(pullup_override_val[i]),
      .dd_oe(dir_override_en[i]),
      .dd_ov(dir_override_val[i]),
      .pv_oe(outval_override_en[i]),
      .pv_ov(outval_override_val[i]),
      .die_oe(input_gate_override_en[i]),
      .die_ov(input_gate_override_val[i]),
      .din_en(din_en[i]),
      .pad_out_ff(pad_out[i]),
      .pad_oe_n_ff(pad_oe_n[i]),
      .pullup_ff(pullup_en[i])
    );
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pullup_normal_a: assert property (!pullup_override_en[0]
    |=> pullup_en[0] == $past(!dir_ff[0] && out_ff[0] && !pud_eff[0]))
    else $error("pull-up does not follow direction, output and disable");
  pullup_ovr_a: assert property (pullup_override_en[0]
    |=> pullup_en[0] == $past(pullup_override_val[0]))
    else $error("pull-up does not follow override value");
  drv_select_a: assert property (!hold_ff[0]
    |=> pad_oe_n[0] == !$past(dir_override_en[0] ? dir_override_val[0] : dir_ff[0]))
    else $error("driver enable wrong source");
  drv_value_a: assert property (!pad_oe_n[0] && $past(outval_override_en[0])
    |-> pad_out[0] == $past(outval_override_val[0]))
    else $error("driven value ignores override");
  drv_port_a: assert property (!pad_oe_n[0] && !$past(outval_override_en[0])
    |-> pad_out[0] == $past(out_ff[0]))
    else $error("driven value not from output bit");
  toggle_ovr_a: assert property (toggle_override_en[0] && !wr_out[0] && !wr_in[0]
    |=> out_ff[0] != $past(out_ff[0]))
    else $error("peripheral toggle did not invert output bit");
  pin_toggle_a: assert property (wr_in[0] && pwdata[0] && !toggle_override_en[0]
    |=> out_ff[0] != $past(out_ff[0]))
    else $error("input register write did not toggle output bit");
  gate_ovr_a: assert property (input_gate_override_en[0]
    |-> din_en[0] == input_gate_override_val[0])
    else $error("input gate ignores override");
  gate_sleep_a: assert property (!input_gate_override_en[0]
    |-> din_en[0] == !sleep_clamp)
    else $error("input gate does not follow sleep state");
  global_pud_a: assert property (mcu_ctrl_ff[`PPOM_BIT_GLOBAL_PUD]
    |-> &pud_eff)
    else $error("global disable did not reach every port");
  bbm_gap_a: assert property (wr_dir[0] && pwdata[0] && !dir_ff[0] && bbm[0]
    && !dir_override_en[0] ##1 !dir_override_en[0] ##1 !dir_override_en[0] && !wr_dir[0]
    |-> pad_oe_n[0] ##1 !pad_oe_n[0])
    else $error("break-before-make gap not exactly one cycle");
  no_gap_fall_a: assert property ($fell(dir_ff[0]) |-> !hold_ff[0])
    else $error("gap inserted on output to input change");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("APB answer not in the access cycle");
  drv_force_a: assert property (dir_override_en[0] && !hold_ff[0]
    |=> pad_oe_n[0] == !$past(dir_override_val[0]))
    else $error("driver enable ignores direction override");
  bbm_arm_a: assert property (wr_dir[0] && pwdata[0] && !dir_ff[0] && bbm[0]
    |=> hold_ff[0])
    else $error("break-before-make gap not armed");
  bbm_off_a: assert property (!bbm[0] |=> !hold_ff[0])
    else $error("gap inserted with break-before-make off");
  hold_short_a: assert property (hold_ff[0] |=> !hold_ff[0])
    else $error("tri-state gap longer than one cycle");
  port_pud_a: assert property (port_pud[0] |-> &pud_eff[NPIN-1:0])
    else $error("port A disable did not reach every pin");
  pud_block_a: assert property (pud_eff[0] && !pullup_override_en[0]
    |=> !pullup_en[0])
    else $error("pull-up on although disabled");
  pud_or_a: assert property (pud_eff[0]
    == (port_ctrl_ff[`PPOM_BIT_PUD_A] | mcu_ctrl_ff[`PPOM_BIT_GLOBAL_PUD]))
    else $error("port A disable is not port OR global");
  raw_gate_a: assert property (!din_en[0] |-> !alt_func_raw_input[0])
    else $error("gated raw input not forced low");
  spare_store_a: assert property (wr_en && paddr == `PPOM_OFS_PORT_CTRL
    |=> port_ctrl_ff == $past(pwdata[7:0]))
    else $error("port control write not stored");

  // Port B mirrors, pin NPIN, so the second port's strobes and selects are exercised
  pullup_normal_b_a: assert property (!pullup_override_en[NPIN]
    |=> pullup_en[NPIN] == $past(!dir_ff[NPIN] && out_ff[NPIN] && !pud_eff[NPIN]))
    else $error("port B pull-up does not follow register bits");
  pullup_ovr_b_a: assert property (pullup_override_en[NPIN]
    |=> pullup_en[NPIN] == $past(pullup_override_val[NPIN]))
    else $error("port B pull-up does not follow override value");
  drv_select_b_a: assert property (!hold_ff[NPIN]
    |=> pad_oe_n[NPIN] == !$past(dir_override_en[NPIN] ? dir_override_val[NPIN]
    : dir_ff[NPIN]))
    else $error("port B driver enable wrong source");
  drv_force_b_a: assert property (dir_override_en[NPIN] && !hold_ff[NPIN]
    |=> pad_oe_n[NPIN] == !$past(dir_override_val[NPIN]))
    else $error("port B driver enable ignores direction override");
  drv_value_b_a: assert property (!pad_oe_n[NPIN] && $past(outval_override_en[NPIN])
    |-> pad_out[NPIN] == $past(outval_override_val[NPIN]))
    else $error("port B driven value ignores override");
  drv_port_b_a: assert property (!pad_oe_n[NPIN] && !$past(outval_override_en[NPIN])
    |-> pad_out[NPIN] == $past(out_ff[NPIN]))
    else $error("port B driven value not from output bit");
  toggle_b_a: assert property (toggle_override_en[NPIN] && !wr_out[1] && !wr_in[1]
    |=> out_ff[NPIN] != $past(out_ff[NPIN]))
    else $error("port B peripheral toggle did not invert output bit");
  pin_toggle_b_a: assert property (wr_in[1] && pwdata[0] && !toggle_override_en[NPIN]
    |=> out_ff[NPIN] != $past(out_ff[NPIN]))
    else $error("port B input register write did not toggle");
  gate_ovr_b_a: assert property (input_gate_override_en[NPIN]
    |-> din_en[NPIN] == input_gate_override_val[NPIN])
    else $error("port B input gate ignores override");
  gate_sleep_b_a: assert property (!input_gate_override_en[NPIN]
    |-> din_en[NPIN] == !sleep_clamp)
    else $error("port B input gate does not follow sleep state");
  bbm_arm_b_a: assert property (wr_dir[1] && pwdata[0] && !dir_ff[NPIN] && bbm[1]
    |=> hold_ff[NPIN])
    else $error("port B break-before-make gap not armed");
  no_gap_b_a: assert property ($fell(dir_ff[NPIN]) |-> !hold_ff[NPIN])
    else $error("port B gap inserted on output to input change");
  port_pud_b_a: assert property (port_pud[1] |-> &pud_eff[NP-1:NPIN])
    else $error("port B disable did not reach every pin");
  pud_or_b_a: assert property (pud_eff[NPIN]
    == (port_ctrl_ff[`PPOM_BIT_PUD_B] | mcu_ctrl_ff[`PPOM_BIT_GLOBAL_PUD]))
    else $error("port B disable is not port OR global");
  raw_gate_b_a: assert property (!din_en[NPIN] |-> !alt_func_raw_input[NPIN])
    else $error("port B gated raw input not forced low");

  bbm_seen_c: cover property (hold_ff[0] ##1 !pad_oe_n[0]);
  toggle_seen_c: cover property (toggle_override_en[NPIN]);
  unmapped_seen_c: cover property (pslverr);
  sleep_gate_c: cover property (sleep_clamp && input_gate_override_en[0]);
  pullup_force_c: cover property (pullup_override_en[0] && pullup_override_val[0]);
endmodule

// ---- sim/ppom_periph_model.sv ----
// Peripheral side model: launches pin override requests from its own flops.
// Assumes the bench sets requests on clk and feeds back the raw pad input.
`timescale 1ns/100ps

module ppom_periph_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [143:0] req,
  input wire logic [15:0] raw_in,
  output logic [15:0] pu_oe,
  output logic [15:0] pu_ov,
  output logic [15:0] dd_oe,
  output logic [15:0] dd_ov,
  output logic [15:0] pv_oe,
  output logic [15:0] pv_ov,
  output logic [15:0] tog,
  output logic [15:0] die_oe,
  output logic [15:0] die_ov,
  output logic [15:0] raw_sync_ff
);
  logic [143:0] req_ff;
  logic [15:0] meta_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ff <= '0;
    end else begin
      req_ff <= req;
    end
  end
  assign {die_ov, die_oe, tog, pv_ov, pv_oe, dd_ov, dd_oe, pu_ov, pu_oe} = req_ff;

  // Raw input arrives unsynchronised, so this receiver adds two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      raw_sync_ff <= '0;
    end else begin
      meta_ff <= raw_in;
      raw_sync_ff <= meta_ff;
    end
  end
endmodule

// ---- sim/tb_port_pin_override_mux.sv ----
// Self-checking bench for the pin override mux, pin 0 of port A in focus.
// Assumes pads read high; the peripheral model adds one cycle to overrides.
`timescale 1ns/100ps

module tb_port_pin_override_mux import ppom_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sleep_clamp = 1'b0;
  logic [7:0] paddr = 8'h00;
  ppom_word_t pwdata = 32'h0;
  ppom_word_t prdata;
  ppom_word_t rd;
  logic pready, pslverr, er;
  logic [15:0] pad_out, pad_oe_n, pullup_en, raw;
  logic [15:0] pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, tog, die_oe, die_ov;
  logic [143:0] req = '0;
  int n_fail = 0;
  int n_tests = 0;
  // Row: dir,out,pud,gpud,pu_oe,pu_ov,dd_oe,dd_ov,pv_oe,pv_ov,die_oe,die_ov,sleep | pu,oe_n,out,raw
  logic [16:0] rows [13] = '{
    17'h0800d,
    17'h0c005,
    17'h0a005,
    17'h0180d,
    17'h09005,
    17'h18003,
    17'h18405,
    17'h0c603,
    17'h18101,
    17'h10183,
    17'h00014,
    17'h00075,
    17'h00044
  };

  always #25 clk = ~clk;

  ppom_top #(.NPIN(8)) u_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_clamp(sleep_clamp), .pad_in(16'hffff), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pullup_en(pullup_en), .alt_func_raw_input(raw),
    .pullup_override_en(pu_oe), .pullup_override_val(pu_ov),
    .dir_override_en(dd_oe), .dir_override_val(dd_ov),
    .outval_override_en(pv_oe), .outval_override_val(pv_ov), .toggle_override_en(tog),
    .input_gate_override_en(die_oe), .input_gate_override_val(die_ov)
  );

  ppom_periph_model u_periph (
    .clk(clk), .rst_n(rst_n), .req(req), .raw_in(raw), .pu_oe(pu_oe), .pu_ov(pu_ov),
    .dd_oe(dd_oe), .dd_ov(dd_ov), .pv_oe(pv_oe), .pv_ov(pv_ov), .tog(tog),
    .die_oe(die_oe), .die_ov(die_ov), .raw_sync_ff()
  );

  function automatic logic [143:0] mk(input logic [12:0] r);
    mk = '0;
    mk[0] = r[8];
    mk[16] = r[7];
    mk[32] = r[6];
    mk[48] = r[5];
    mk[64] = r[4];
    mk[80] = r[3];
    mk[112] = r[2];
    mk[128] = r[1];
  endfunction

  // Request held until pready is sampled high; read data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input ppom_word_t d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string s, input ppom_word_t e, input ppom_word_t g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    chk("oe_n_rst", 32'hffff, 32'(pad_oe_n));
    chk("pu_rst", 32'h0, 32'(pullup_en));
    rst_n <= 1'b1;
    apb(1'b0, 8'h18, 32'h0);
    chk("port_control", 32'h0, rd);
    foreach (rows[i]) begin
      req <= mk(rows[i][16:4]);
      sleep_clamp <= rows[i][4];
      apb(1'b1, 8'h00, 32'(rows[i][16]));
      apb(1'b1, 8'h04, 32'(rows[i][15]));
      apb(1'b1, 8'h18, 32'(rows[i][14]));
      apb(1'b1, 8'h1c, 32'(rows[i][13]) << 4);
      repeat (3) @(posedge clk);
      #1;
      chk("pin0", 32'(rows[i][3:0]), 32'({pullup_en[0], pad_oe_n[0], pad_out[0], raw[0]}));
    end
    req <= '0;
    sleep_clamp <= 1'b0;
    apb(1'b1, 8'h18, 32'hcc);
    apb(1'b0, 8'h18, 32'h0);
    chk("ctrl_spare", 32'hcc, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, 32'(er));
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b0, 8'h08, 32'h0);
    chk("in_a", 32'hff, rd);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h1);
    @(posedge clk);
    req <= 144'h1 << 97;
    @(posedge clk);
    req <= '0;
    apb(1'b0, 8'h04, 32'h0);
    chk("out_a", 32'h3, rd);
    apb(1'b1, 8'h18, 32'h10);
    apb(1'b1, 8'h00, 32'h1);
    @(posedge clk);
    #1;
    chk("bbm_gap", 32'h1, 32'(pad_oe_n[0]));
    @(posedge clk);
    #1;
    chk("bbm_end", 32'h0, 32'(pad_oe_n[0]));
    chk("bbm_val", 32'h1, 32'(pad_out[0]));
    apb(1'b1, 8'h00, 32'h0);
    @(posedge clk);
    #1;
    chk("to_input", 32'h1, 32'(pad_oe_n[0]));
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    @(posedge clk);
    #1;
    chk("no_bbm", 32'h0, 32'(pad_oe_n[0]));
    report_and_stop;
  end

  // The whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
endmodule
